// ==== src/cai_front_end.sv ====
// coded audio input front end: master/slave serial inputs, decode control
//
// Behaviour
// (RL1) reset held 24 or 12 master clocks
// (RL2) reset mutes, drops sync, clears settings
// (RL3) stop halts decoding and master requests
// (RL4) stop freezes master word select
// (RL5) stop means sync lost, resync after
// (RL6) stop answered within half sample period
// (RL7) unreliable data mutes; requests keep going
// (RL8) master input: no free format, broadcast
// (RL9) master bit clock fixed at 768 kHz
// (RL10) word select toggle, then 16 bits read
// (RL11) master frames start on byte boundary
// (RL12) toggle spacing near 16*768 over bitrate
// (RL13) master error flag merged per byte
// (RL14) slave clock between bitrate and 768 kHz
// (RL15) slave error merged, ignored outside window
// (RL16) slave bit taken only inside window
// (RL17) first valid bit after sync edge starts frame
// (RL18) frame sync high and low once per frame
// (RL19) sync edge in gap: next window bit starts
// (RL20) mode flags select frame sync use
// (RL21) window may change every slave clock
// (RL22) no sync: byte bursts, byte-aligned frames
// (RL23) resume at last master spacing
// (RL24) default master rate 384 kbit/s
// (RL25) slave pins sampled then synchronised
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module cai_front_end (
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_stop,
    input  wire logic        i_unreliable_data_in,
    input  wire logic        i_master_coded_data_in,
    input  wire logic        i_master_coded_error_flag,
    output logic             o_master_coded_bit_clock,
    output logic             o_master_coded_word_select,
    input  wire logic        i_slave_coded_data_in,
    input  wire logic        i_slave_coded_error_flag,
    input  wire logic        i_slave_coded_bit_clock,
    input  wire logic        i_slave_burst_window,
    input  wire logic        i_slave_frame_sync,
    input  wire logic        i_sync_found,
    output logic             o_mute,
    output logic             o_sync_drop,
    output logic             o_byte_valid,
    output logic      [7:0]  o_byte,
    output logic             o_byte_err,
    output logic             o_byte_first,
    output logic             o_slave_active,
    output logic             o_sync_mode_sel_hi,
    output logic             o_sync_mode_sel_lo,
    output logic             o_broadcast_frame_format,
    output logic             o_ext_sample_clock_mode
);
    logic [cai_pkg::SY_W-1:0] sy;
    logic [4:0]  ctrl_r;
    logic [7:0]  spacing_r;
    logic [7:0]  spc_eff;
    logic [31:0] rd_val;
    logic        stop_s, unrel_s, drop, slave_sel;
    logic [17:0] acc_r, acc_sum;
    logic        m_rise, m_fall;
    logic [7:0]  per_cnt_r, hp_cnt_r;
    logic [4:0]  rd_cnt_r;
    logic        skip_r;
    logic        s_clk_prev_r, s_edge, fs_prev_r, fs_pend_r, fs_used, fs_rise;
    logic        m_take, s_take, bit_take, bit_val, bit_err, bit_first;
    logic [6:0]  sh_r;
    logic [2:0]  as_cnt_r, as_cur;
    logic        as_err_r, as_first_r, err_cur, first_cur;

    // ======================================================
    // pin synchronisers
    cai_sync #(.W(cai_pkg::SY_W)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_async   ({i_slave_frame_sync, i_slave_burst_window, i_slave_coded_bit_clock,
                     i_slave_coded_error_flag, i_slave_coded_data_in, i_master_coded_error_flag,
                     i_master_coded_data_in, i_unreliable_data_in, i_stop}),
        .o_sync    (sy)
    );  // RL25

    assign stop_s    = sy[cai_pkg::SY_STOP];
    assign unrel_s   = sy[cai_pkg::SY_UNREL];
    assign drop      = stop_s | unrel_s;
    assign slave_sel = ctrl_r[cai_pkg::CTL_SLAVE];

    // ======================================================
    // register bus, one wait cycle per access
    assign spc_eff = (spacing_r < cai_pkg::MIN_SPACING) ? cai_pkg::MIN_SPACING : spacing_r;

    always_comb begin
        rd_val = '0;
        unique case (i_avs_address)
            cai_pkg::REG_CTRL:    rd_val = {27'h0, ctrl_r};
            cai_pkg::REG_SPACING: rd_val = {24'h0, spacing_r};
            cai_pkg::REG_STATUS:  rd_val = {26'h0, o_master_coded_word_select, slave_sel,
                                            unrel_s, stop_s, o_sync_drop, o_mute};
            default:              rd_val = '0;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= '0;
        end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata    <= i_avs_read ? rd_val : '0;
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end

    // settings and spacing; spacing survives slave use
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            ctrl_r    <= cai_pkg::CTRL_RST;           // RL2
            spacing_r <= cai_pkg::DEF_SPACING;        // RL24
        end else if (i_avs_write && !o_avs_waitrequest) begin
            if (i_avs_address == cai_pkg::REG_CTRL)
                ctrl_r <= i_avs_writedata[4:0];       // RL20
            if (i_avs_address == cai_pkg::REG_SPACING)
                spacing_r <= i_avs_writedata[7:0];    // RL23
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_slave_active           <= 1'b0;
            o_sync_mode_sel_lo       <= 1'b0;
            o_sync_mode_sel_hi       <= 1'b0;
            o_broadcast_frame_format <= 1'b0;
            o_ext_sample_clock_mode  <= 1'b0;
        end else begin
            o_slave_active           <= slave_sel;
            o_sync_mode_sel_lo       <= ctrl_r[cai_pkg::CTL_MODE_LO];
            o_sync_mode_sel_hi       <= ctrl_r[cai_pkg::CTL_MODE_HI];
            o_broadcast_frame_format <= ctrl_r[cai_pkg::CTL_BCAST];
            o_ext_sample_clock_mode  <= ctrl_r[cai_pkg::CTL_EXTCLK];
        end
    end

    // ======================================================
    // mute and sync loss
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_mute      <= 1'b1;                      // RL2
            o_sync_drop <= 1'b1;
        end else begin
            o_sync_drop <= drop;                      // RL5 RL7
            if (drop)
                o_mute <= 1'b1;                       // RL6 RL7
            else if (i_sync_found)
                o_mute <= 1'b0;                       // RL5
        end
    end

    // ======================================================
    // master bit clock, fractional divider
    assign acc_sum = acc_r + cai_pkg::ACC_STEP;
    assign m_rise  = (acc_sum >= cai_pkg::ACC_MOD) && !o_master_coded_bit_clock;
    assign m_fall  = (acc_sum >= cai_pkg::ACC_MOD) && o_master_coded_bit_clock;

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            acc_r                    <= '0;
            o_master_coded_bit_clock <= 1'b0;
            hp_cnt_r                 <= '0;
        end else if (acc_sum >= cai_pkg::ACC_MOD) begin
            acc_r                    <= acc_sum - cai_pkg::ACC_MOD;
            o_master_coded_bit_clock <= !o_master_coded_bit_clock;  // RL9
            hp_cnt_r                 <= '0;
        end else begin
            acc_r                    <= acc_sum;
            hp_cnt_r                 <= hp_cnt_r + 8'h01;
        end
    end

    // ======================================================
    // master request sequencer
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_master_coded_word_select <= 1'b0;
            per_cnt_r                  <= '0;
            rd_cnt_r                   <= '0;
            skip_r                     <= 1'b0;
        end else if (m_fall) begin
            if (slave_sel || stop_s) begin
                per_cnt_r <= '0;                      // RL3 RL4
            end else if (per_cnt_r >= spc_eff - 8'h01) begin
                o_master_coded_word_select <= !o_master_coded_word_select;  // RL10 RL12
                per_cnt_r                  <= '0;
                rd_cnt_r                   <= cai_pkg::BURST_LEN;
                skip_r                     <= 1'b1;
            end else begin
                per_cnt_r <= per_cnt_r + 8'h01;
            end
        end else if (m_rise) begin
            if (skip_r)
                skip_r <= 1'b0;                       // RL10
            else if (rd_cnt_r != '0)
                rd_cnt_r <= rd_cnt_r - 5'h01;
        end
    end

    assign m_take = m_rise && !skip_r && (rd_cnt_r != '0) && !slave_sel && !stop_s;  // RL3

    // ======================================================
    // slave input, edge of synchronised bit clock
    assign s_edge  = sy[cai_pkg::SY_SCLK] && !s_clk_prev_r;
    assign fs_used = ctrl_r[cai_pkg::CTL_MODE_HI] || ctrl_r[cai_pkg::CTL_BCAST];  // RL20
    assign fs_rise = fs_used && sy[cai_pkg::SY_SFS] && !fs_prev_r;
    assign s_take  = s_edge && sy[cai_pkg::SY_SWIN] && slave_sel && !stop_s;      // RL16 RL21

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            s_clk_prev_r <= 1'b0;
            fs_prev_r    <= 1'b0;
            fs_pend_r    <= 1'b0;
        end else begin
            s_clk_prev_r <= sy[cai_pkg::SY_SCLK];
            if (s_edge) begin
                fs_prev_r <= sy[cai_pkg::SY_SFS];
                if (s_take)
                    fs_pend_r <= 1'b0;                // RL17
                else if (fs_rise)
                    fs_pend_r <= 1'b1;                // RL19
            end
        end
    end

    // ======================================================
    // bit merge and byte grouping
    assign bit_take  = m_take || s_take;
    assign bit_val   = slave_sel ? sy[cai_pkg::SY_SDAT] : sy[cai_pkg::SY_MDAT];
    assign bit_err   = slave_sel ? sy[cai_pkg::SY_SERR] : sy[cai_pkg::SY_MERR];  // RL15
    assign bit_first = s_take && (fs_pend_r || fs_rise);                         // RL17 RL19
    assign as_cur    = bit_first ? 3'h0 : as_cnt_r;
    assign err_cur   = bit_err || (!bit_first && as_err_r);                      // RL13 RL15
    assign first_cur = bit_first || as_first_r;

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || drop) begin
            as_cnt_r     <= '0;                       // RL5
            as_err_r     <= 1'b0;
            as_first_r   <= 1'b0;
            sh_r         <= '0;
            o_byte_valid <= 1'b0;
            o_byte       <= '0;
            o_byte_err   <= 1'b0;
            o_byte_first <= 1'b0;
        end else begin
            o_byte_valid <= 1'b0;
            if (bit_take) begin
                sh_r <= {sh_r[5:0], bit_val};
                if (as_cur == cai_pkg::GROUP_LAST) begin
                    o_byte_valid <= 1'b1;
                    o_byte       <= {sh_r, bit_val};
                    o_byte_err   <= err_cur;          // RL13
                    o_byte_first <= first_cur;
                    as_cnt_r     <= '0;
                    as_err_r     <= 1'b0;
                    as_first_r   <= 1'b0;
                end else begin
                    as_cnt_r     <= as_cur + 3'h1;
                    as_err_r     <= err_cur;
                    as_first_r   <= first_cur;
                end
            end
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_stop_rise;
        $rose(stop_s);
    endsequence
    sequence s_muted_dropped;
        o_mute && o_sync_drop;
    endsequence

    property p_reset_mute;
        $rose(i_nrst) |-> o_mute && o_sync_drop && !o_byte_valid;
    endproperty
    a_reset_mute: assert property (p_reset_mute) else $error("reset did not mute");  // RL2

    property p_stop_resp;
        s_stop_rise |-> ##[1:2] s_muted_dropped;
    endproperty
    a_stop_resp: assert property (p_stop_resp) else $error("stop not answered");  // RL6

    property p_ws_frozen;
        stop_s && $past(stop_s) |=> $stable(o_master_coded_word_select);
    endproperty
    a_ws_frozen: assert property (p_ws_frozen) else $error("word select moved in stop");  // RL4

    property p_no_take_stop;
        stop_s |-> !bit_take && !o_byte_valid;
    endproperty
    a_no_take_stop: assert property (p_no_take_stop) else $error("data taken in stop");  // RL3

    property p_unrel;
        $rose(unrel_s) |-> ##[1:2] s_muted_dropped;
    endproperty
    a_unrel: assert property (p_unrel) else $error("unreliable not answered");  // RL7

    property p_bitclk;
        hp_cnt_r <= cai_pkg::HALF_MAX;
    endproperty
    a_bitclk: assert property (p_bitclk) else $error("bit clock half period too long");  // RL9

    property p_spacing;
        $changed(o_master_coded_word_select) |-> $past(per_cnt_r) == spc_eff - 8'h01;
    endproperty
    a_spacing: assert property (p_spacing) else $error("request spacing wrong");  // RL12

    property p_burst;
        $changed(o_master_coded_word_select) |-> rd_cnt_r == cai_pkg::BURST_LEN && skip_r;
    endproperty
    a_burst: assert property (p_burst) else $error("burst not armed");  // RL10

    property p_group;
        o_byte_valid |-> $past(as_cur) == cai_pkg::GROUP_LAST && $past(bit_take);
    endproperty
    a_group: assert property (p_group) else $error("byte emitted off group");  // RL13

    property p_window;
        slave_sel && s_edge && !sy[cai_pkg::SY_SWIN] |=> !o_byte_valid;
    endproperty
    a_window: assert property (p_window) else $error("slave bit outside window");  // RL16

    property p_gap_sync;
        fs_pend_r && s_take && !drop |=> as_cnt_r == 3'h1 && as_first_r;
    endproperty
    a_gap_sync: assert property (p_gap_sync) else $error("pending frame start lost");  // RL19
endmodule : cai_front_end

// ==== src/cai_pkg.sv ====
// constants shared by the coded audio input front end
package cai_pkg;
    // ======================================================
    // clocking
    localparam int          CLK_KHZ     = 200000;
    localparam int          MCLK_KHZ    = 768;
    localparam logic [17:0] ACC_MOD     = 18'(CLK_KHZ);
    localparam logic [17:0] ACC_STEP    = 18'(2 * MCLK_KHZ);
    localparam logic [7:0]  HALF_MAX    = 8'(CLK_KHZ / (2 * MCLK_KHZ) + 1);
    // ======================================================
    // master request timing
    localparam int          BURST_BITS  = 16;
    localparam int          DEF_KBPS    = 384;
    localparam logic [7:0]  DEF_SPACING = 8'(BURST_BITS * MCLK_KHZ / DEF_KBPS);
    localparam logic [7:0]  MIN_SPACING = 8'(BURST_BITS + 1);
    localparam logic [4:0]  BURST_LEN   = 5'(BURST_BITS);
    localparam logic [2:0]  GROUP_LAST  = 3'h7;
    // ======================================================
    // register map (byte offsets)
    localparam logic [3:0]  REG_CTRL    = 4'h0;
    localparam logic [3:0]  REG_SPACING = 4'h4;
    localparam logic [3:0]  REG_STATUS  = 4'h8;
    localparam logic [4:0]  CTRL_RST    = 5'h00;
    localparam int          CTL_SLAVE   = 0;
    localparam int          CTL_MODE_LO = 1;
    localparam int          CTL_MODE_HI = 2;
    localparam int          CTL_BCAST   = 3;
    localparam int          CTL_EXTCLK  = 4;
    // ======================================================
    // synchroniser lanes
    localparam int          SY_W        = 9;
    localparam int          SY_STOP     = 0;
    localparam int          SY_UNREL    = 1;
    localparam int          SY_MDAT     = 2;
    localparam int          SY_MERR     = 3;
    localparam int          SY_SDAT     = 4;
    localparam int          SY_SERR     = 5;
    localparam int          SY_SCLK     = 6;
    localparam int          SY_SWIN     = 7;
    localparam int          SY_SFS      = 8;
endpackage : cai_pkg

// ==== src/cai_sync.sv ====
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module cai_sync #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    // ======================================================
    // first stage feeds only the second
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule : cai_sync

// ==== test/cai_src_model.sv ====
// source model for the master coded input: answers each word select toggle with one burst
`timescale 1ns/1ps
module cai_src_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_bit_clock,
    input  wire logic        i_word_select,
    input  wire logic [15:0] i_word,
    input  wire logic [15:0] i_err,
    output logic             o_data,
    output logic             o_err
);
    logic        ws_r;
    logic        bc_r;
    logic [4:0]  left_r;
    logic [15:0] dat_r;
    logic [15:0] err_r;
    // ======================================================
    // burst shifter, bits change on bit clock falls
    always_ff @(posedge i_sys_clk) begin
        ws_r <= i_word_select;
        bc_r <= i_bit_clock;
        if (!i_nrst) begin
            left_r <= 5'h00;
            o_data <= 1'b0;
            o_err  <= 1'b0;
        end else if (ws_r != i_word_select) begin
            left_r <= 5'h10;
            dat_r  <= i_word;
            err_r  <= i_err;
        end else if (bc_r && !i_bit_clock) begin
            if (left_r != 5'h00) begin
                o_data <= dat_r[15];
                o_err  <= err_r[15];
                dat_r  <= {dat_r[14:0], 1'b0};
                err_r  <= {err_r[14:0], 1'b0};
                left_r <= left_r - 5'h01;
            end else begin
                // released line: never a stale level
                o_data <= ~o_data;
                o_err  <= ~o_err;
            end
        end
    end
endmodule : cai_src_model

// ==== test/tb_top.sv ====
// self-checking testbench of the coded audio input front end
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
    logic        i_sys_clk = 1'b0;
    logic        i_nrst    = 1'b0;
    logic [3:0]  adr       = 4'h0;
    logic        rd        = 1'b0;
    logic        wr        = 1'b0;
    logic [31:0] wdat      = 32'h0;
    logic [31:0] rdat;
    logic        wreq;
    logic        stop      = 1'b0;
    logic        unrel     = 1'b0;
    logic        found     = 1'b0;
    logic        mdat;
    logic        merr;
    logic        bclk;
    logic        ws;
    logic        sd        = 1'b0;
    logic        se        = 1'b0;
    logic        scl       = 1'b0;
    logic        sw        = 1'b0;
    logic        sfs       = 1'b0;
    logic        mute;
    logic        sdrop;
    logic        bval;
    logic [7:0]  bdat;
    logic        berr;
    logic        bfirst;
    logic        slv;
    wire logic [3:0] cfg;
    logic [31:0] d;
    logic [9:0]  bq[$];
    int          n_errors  = 0;
    int          checks    = 0;
    int          n;
    always #2.5 i_sys_clk = ~i_sys_clk;
    cai_front_end uut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .i_stop(stop), .i_unreliable_data_in(unrel), .i_master_coded_data_in(mdat),
        .i_master_coded_error_flag(merr), .o_master_coded_bit_clock(bclk), .o_master_coded_word_select(ws),
        .i_slave_coded_data_in(sd), .i_slave_coded_error_flag(se), .i_slave_coded_bit_clock(scl),
        .i_slave_burst_window(sw), .i_slave_frame_sync(sfs), .i_sync_found(found), .o_mute(mute),
        .o_sync_drop(sdrop), .o_byte_valid(bval), .o_byte(bdat), .o_byte_err(berr), .o_byte_first(bfirst),
        .o_slave_active(slv), .o_sync_mode_sel_hi(cfg[2]), .o_sync_mode_sel_lo(cfg[1]),
        .o_broadcast_frame_format(cfg[3]), .o_ext_sample_clock_mode(cfg[0]));
    cai_src_model u_src (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_bit_clock(bclk), .i_word_select(ws),
        .i_word(16'ha53c), .i_err(16'h0010), .o_data(mdat), .o_err(merr));
    // ======================================================
    // byte capture and helpers
    always @(posedge i_sys_clk) if (bval === 1'b1) bq.push_back({bfirst, berr, bdat});
    task bus(input logic w, input logic [3:0] a, input logic [31:0] v);
        int t;
        t = 0;
        @(posedge i_sys_clk);
        rd   <= ~w;
        wr   <= w;
        adr  <= a;
        wdat <= v;
        do begin @(posedge i_sys_clk); t++; end while (wreq !== 1'b0 && t < 100);
        d = rdat;
        if (t >= 100) n_errors++;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task do_reset;
        @(posedge i_sys_clk);
        i_nrst <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
    endtask : do_reset
    task pulse_found;
        repeat (5) @(posedge i_sys_clk);
        found <= 1'b1;
        @(posedge i_sys_clk);
        found <= 1'b0;
        repeat (4) @(negedge i_sys_clk);
    endtask : pulse_found
    // counts bit clock rises between two word select toggles
    task spacing(output int r);
        int   t;
        logic w;
        logic b;
        r = 0;
        t = 0;
        @(negedge i_sys_clk);
        w = ws;
        while (ws === w && t < 12000) begin @(negedge i_sys_clk); t++; end
        if (ws === w) return;
        t = 0;
        w = ws;
        b = bclk;
        while (ws === w && t < 12000) begin
            @(negedge i_sys_clk);
            t++;
            if (bclk && !b) r++;
            b = bclk;
        end
    endtask : spacing
    task wait_bytes(input int k);
        int t;
        t = 0;
        while (bq.size() < k && t < 8000) begin @(negedge i_sys_clk); t++; end
        if (bq.size() < k) n_errors++;
    endtask : wait_bytes
    task sbit(input logic v, input logic e, input logic w, input logic f);
        @(posedge i_sys_clk);
        sd  <= v;
        se  <= e;
        sw  <= w;
        sfs <= f;
        repeat (140) @(posedge i_sys_clk);
        scl <= 1'b1;
        repeat (140) @(posedge i_sys_clk);
        scl <= 1'b0;
    endtask : sbit
    task sbyte(input logic [7:0] v, input logic [7:0] e, input logic g);
        for (int i = 7; i >= 0; i--) begin
            sbit(v[i], e[i], 1'b1, 1'b0);
            if (i == 5 && g) sbit(~v[i], 1'b1, 1'b0, 1'b0);
        end
    endtask : sbyte
    task report_and_stop;
        if (n_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    // ======================================================
    // tests
    initial begin
        repeat (95000) @(posedge i_sys_clk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        do_reset();
        @(negedge i_sys_clk);
        `CHK({mute, sdrop, ws, bclk, slv, cfg}, 9'h180)
        bus(1'b1, 4'h8, 32'h3f);
        bus(1'b0, 4'h8, 32'h0);
        `CHK(d, 32'h1)
        bus(1'b0, 4'h4, 32'h0);
        `CHK(d, 32'h20)
        bus(1'b0, 4'hc, 32'h0);
        `CHK(d, 32'h0)
        bus(1'b1, 4'h0, 32'h1e);
        bus(1'b0, 4'h0, 32'h0);
        `CHK({d[7:0], cfg}, 12'h1ef)
        bus(1'b1, 4'h0, 32'h0);
        pulse_found();
        `CHK({mute, sdrop}, 2'b00)
        spacing(n);
        `CHK(n, 32)
        bq.delete();
        wait_bytes(2);
        `CHK(bq[0], 10'h0a5)
        `CHK(bq[1], 10'h13c)
        bus(1'b1, 4'h4, 32'h11);
        spacing(n);
        spacing(n);
        `CHK(n, 17)
        @(posedge i_sys_clk);
        stop <= 1'b1;
        repeat (4) @(negedge i_sys_clk);
        `CHK({mute, sdrop}, 2'b11)
        repeat (300) @(negedge i_sys_clk);
        bq.delete();
        spacing(n);
        `CHK(n, 0)
        `CHK(bq.size(), 0)
        pulse_found();
        `CHK(mute, 1'b1)
        @(posedge i_sys_clk);
        stop <= 1'b0;
        pulse_found();
        `CHK(mute, 1'b0)
        spacing(n);
        `CHK(n, 17)
        @(posedge i_sys_clk);
        unrel <= 1'b1;
        repeat (5) @(negedge i_sys_clk);
        `CHK({mute, sdrop}, 2'b11)
        spacing(n);
        `CHK(n, 17)
        @(posedge i_sys_clk);
        unrel <= 1'b0;
        bus(1'b1, 4'h0, 32'h05);
        repeat (2) @(negedge i_sys_clk);
        `CHK({slv, cfg[2]}, 2'b11)
        bq.delete();
        repeat (3) sbit(1'b1, 1'b0, 1'b1, 1'b0);
        sbit(1'b0, 1'b1, 1'b0, 1'b1);
        sbyte(8'hc6, 8'h00, 1'b1);
        sbyte(8'h5a, 8'h08, 1'b1);
        wait_bytes(2);
        `CHK(bq.size(), 2)
        `CHK(bq[0], 10'h2c6)
        `CHK(bq[1], 10'h15a)
        bus(1'b1, 4'h0, 32'h01);
        bq.delete();
        sbit(1'b0, 1'b0, 1'b0, 1'b1);
        sbyte(8'h81, 8'h00, 1'b0);
        wait_bytes(1);
        `CHK(bq.size(), 1)
        `CHK(bq[0], 10'h081)
        do_reset();
        bus(1'b0, 4'h0, 32'h0);
        `CHK(d, 32'h0)
        bus(1'b0, 4'h4, 32'h0);
        `CHK(d, 32'h20)
        report_and_stop();
    end
endmodule : tb_top
